// File: ilpc_defines.svh
// constants of the interrupt and low-power control block
// Notes on behaviour
// - option register write-only, no bit operations
// - reset clears option register to zero
// - bit 6 one makes source 1 level
// - bit 5 picks source 2 edge direction
// - bit 4 enables maskables; non-maskable always
// - gen low: non-maskable serviced, no wake
// - bit 7 and bits 3-0 ignored
// - reload timer flags, 8-bit timer on source 3
// - converter source 4, serial 1, pins 2
// - wait halts core, oscillator keeps running
// - wait exit has no stabilisation delay
// - stop only with watchdog off, oscillator halted
// - stop exit inserts stabilisation delay
// - reset during low power gives normal reset
// - main routine sleep: service then continue
// - non-maskable sleep: wake, continue, no service
// - maskable sleep, maskable wake: continue routine
// - maskable sleep, non-maskable wake: service first
// - active watchdog turns stop into wait
// - gen low: only reset restarts core
// - pending enabled request skips sleep instruction
// - interrupts leave oscillator selection unchanged
// - polarity one rising, zero falling on source 2
// - edge mode source 1 triggers on falling
// - edge latch set on edge, cleared on service
// - sources 3, 4 level, low, unstored; here they request while flag and enable are high
`ifndef ILPC_DEFINES_SVH
`define ILPC_DEFINES_SVH
`define ILPC_OPT_ADDR      8'hC8
`define ILPC_OPT_RESET     8'h00
`define ILPC_BIT_LES       6
`define ILPC_BIT_ESB       5
`define ILPC_BIT_GEN       4
`define ILPC_STAB_CYCLES   4096
`define ILPC_SYNC_STAGES   3
`define ILPC_SRC_NMI       3'h0
`define ILPC_SRC_ONE       3'h1
`define ILPC_SRC_TWO       3'h2
`endif

// File: ilpc_pkg.sv
// types of the interrupt and low-power control block
package ilpc_pkg;
	// low-power sequencer states, one-hot
	typedef enum logic [3:0] {
		ILPC_RUN  = 4'h1,
		ILPC_WAIT = 4'h2,
		ILPC_STOP = 4'h4,
		ILPC_STAB = 4'h8
	} ilpc_lp_t;
	// core mode before sleeping
	typedef enum logic [1:0] {
		ILPC_CORE_MAIN = 2'h0,
		ILPC_CORE_IRQ  = 2'h1,
		ILPC_CORE_NMI  = 2'h2
	} ilpc_core_t;
endpackage : ilpc_pkg

// File: ilpc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ilpc_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	// pins in, filtered levels out
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_level
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] lvl_d;

	// an empty bus has nothing to synchronise
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least one");
	end

	// change accepted only when stages two and three agree; pins idle high
	assign lvl_d = (s2_q & s3_q) | (o_level & (s2_q | s3_q));

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			s1_q    <= '1;
			s2_q    <= '1;
			s3_q    <= '1;
			o_level <= '1;
		end else begin
			s1_q    <= i_async;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			o_level <= lvl_d;
		end
	end
endmodule : ilpc_sync
`default_nettype wire

// File: ilpc_edge.sv
// edge request latch for one source
`timescale 1ns/1ps
`default_nettype none
module ilpc_edge (
	// clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst,
	// line, mode and service
	input  wire logic i_line,
	input  wire logic i_rising,
	input  wire logic i_arm,
	input  wire logic i_clear,
	output logic      o_pend
);
	logic prev_q;
	logic hit;

	assign hit = i_arm & (i_rising ? (i_line & ~prev_q) : (~i_line & prev_q));

	// set beats clear; extra edges while pending merge into one
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			prev_q <= 1'b1;
			o_pend <= 1'b0;
		end else begin
			prev_q <= i_line;
			o_pend <= hit | (o_pend & ~i_clear);
		end
	end
endmodule : ilpc_edge
`default_nettype wire

// File: ilpc_ctrl.sv
// interrupt option register, source mapping and low-power sequencer
`include "ilpc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ilpc_ctrl #(
	parameter int STAB_CYCLES = `ILPC_STAB_CYCLES
) (
	// clock and reset
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	// data-space write port from the core
	input  wire logic              i_wr,
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_bitop,
	// external pins, asynchronous
	input  wire logic              i_nmi_pin_n,
	input  wire logic              i_port_irq_pin,
	input  wire logic              i_spi_done_pin_n,
	// peripheral flags and enables, same clock
	input  wire logic              i_reload_overflow_flag,
	input  wire logic              i_reload_overflow_irq_enable,
	input  wire logic              i_compare_match_flag,
	input  wire logic              i_compare_irq_enable,
	input  wire logic              i_timer_zero_flag,
	input  wire logic              i_timer_irq_enable,
	input  wire logic              i_converter_eoc_flag,
	input  wire logic              i_converter_irq_enable,
	// core handshake
	input  wire logic              i_sample,
	input  wire logic              i_svc_start,
	input  wire logic [2:0]        i_svc_src,
	input  wire ilpc_pkg::ilpc_core_t i_core_mode,
	input  wire logic              i_wait_exec,
	input  wire logic              i_stop_exec,
	input  wire logic              i_watchdog_active,
	// requests and sequencing to the core
	output logic [4:0]             o_irq_req,
	output logic                   o_sleep_skip,
	output logic                   o_core_halt,
	output logic                   o_osc_stop,
	output logic                   o_resume,
	output logic                   o_resume_service,
	output logic                   o_opt_gen,
	output logic [2:0]             o_lp_state
);
	import ilpc_pkg::*;

	localparam int CW = $clog2(STAB_CYCLES + 1);
	// reset image of the option register, sliced per field below
	localparam logic [7:0] OPT_RST = `ILPC_OPT_RESET;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// a zero count would never leave the settle state
	if (STAB_CYCLES < 1) begin : g_bad_stab
		$error("STAB_CYCLES must be at least one");
	end
	// field positions must sit inside the written byte
	if (`ILPC_BIT_LES > 7 || `ILPC_BIT_ESB > 7 || `ILPC_BIT_GEN > 7) begin : g_bad_field
		$error("option field outside the data byte");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// service start aimed at one latched source
	function automatic logic svc_hit(
		input logic       start,
		input logic [2:0] src,
		input logic [2:0] which
	);
		return start & (src == which);
	endfunction : svc_hit

	// ----------------------------------------------------------------
	// option register
	// ----------------------------------------------------------------
	logic       les_q;
	logic       esb_q;
	logic       gen_q;
	logic       opt_wr;

	// bit operations on this address are refused; read is never answered
	assign opt_wr = i_wr & ~i_bitop & (i_addr == `ILPC_OPT_ADDR);

	// unused bits are simply never stored
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			les_q <= OPT_RST[`ILPC_BIT_LES];
			esb_q <= OPT_RST[`ILPC_BIT_ESB];
			gen_q <= OPT_RST[`ILPC_BIT_GEN];
		end else if (opt_wr) begin
			les_q <= i_wdata[`ILPC_BIT_LES];
			esb_q <= i_wdata[`ILPC_BIT_ESB];
			gen_q <= i_wdata[`ILPC_BIT_GEN];
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisation and source latches
	// ----------------------------------------------------------------
	logic [2:0] pins;
	logic       nmi_pend;
	logic       s1_pend;
	logic       s2_pend;
	logic       clr0;
	logic       clr1;
	logic       clr2;

	ilpc_sync #(.WIDTH(3)) u_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async ({i_spi_done_pin_n, i_port_irq_pin, i_nmi_pin_n}),
		.o_level (pins)
	);

	// the core names the source it starts; only that latch drops
	assign clr0 = svc_hit(i_svc_start, i_svc_src, `ILPC_SRC_NMI);
	assign clr1 = svc_hit(i_svc_start, i_svc_src, `ILPC_SRC_ONE);
	assign clr2 = svc_hit(i_svc_start, i_svc_src, `ILPC_SRC_TWO);

	// non-maskable latch, falling edge of the pin
	ilpc_edge u_nmi (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_line   (pins[0]),
		.i_rising (1'b0),
		.i_arm    (1'b1),
		.i_clear  (clr0),
		.o_pend   (nmi_pend)
	);

	// source 1 latch, only armed in edge mode
	ilpc_edge u_s1 (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_line   (pins[2]),
		.i_rising (1'b0),
		.i_arm    (~les_q),
		.i_clear  (clr1 | les_q),
		.o_pend   (s1_pend)
	);

	// source 2 always edge, polarity from option register
	ilpc_edge u_s2 (
		.i_clock  (i_clock),
		.i_rst    (i_rst),
		.i_line   (pins[1]),
		.i_rising (esb_q),
		.i_arm    (1'b1),
		.i_clear  (clr2),
		.o_pend   (s2_pend)
	);

	// ----------------------------------------------------------------
	// request mapping
	// ----------------------------------------------------------------
	logic       src1;
	logic       src3;
	logic       src4;
	logic [4:0] req;
	logic       mask_any;
	logic       any_wake;

	// level mode follows the pin with no storage, edge mode the latch
	assign src1 = les_q ? ~pins[2] : s1_pend;
	// peripheral flags arrive on this clock, so no synchroniser
	assign src3 = (i_reload_overflow_flag & i_reload_overflow_irq_enable)
		| (i_compare_match_flag & i_compare_irq_enable)
		| (i_timer_zero_flag & i_timer_irq_enable);
	assign src4 = i_converter_eoc_flag & i_converter_irq_enable;
	// bit 0 stays clear here; the nmi path bypasses the gen mask
	assign req = {src4, src3, s2_pend, src1, 1'b0} & {5{gen_q}};
	assign mask_any = |req;
	// gen low blocks every wake, the nmi one too
	assign any_wake = gen_q & (mask_any | nmi_pend);

	// ----------------------------------------------------------------
	// low-power sequencer
	// ----------------------------------------------------------------
	ilpc_lp_t   st_q;
	ilpc_lp_t   st_d;
	ilpc_core_t mode_q;
	logic [CW-1:0] cnt_q;
	logic          stop_ok;
	logic          sleep_req;
	logic          pend_en;
	logic          wake_go;
	logic          svc_d;
	logic          mode_cap;
	logic          cnt_load;
	logic          cnt_run;
	logic          stab_last;

	// any pending request, enabled or nmi, refuses a sleep
	assign pend_en = mask_any | nmi_pend;
	assign sleep_req = i_wait_exec | i_stop_exec;
	assign stop_ok = i_stop_exec & ~i_watchdog_active;
	// the core mode is caught with the sleep request, even a refused one
	assign mode_cap  = (st_q == ILPC_RUN) & sleep_req;
	// the settle count reloads for as long as the oscillator is off
	assign cnt_load  = st_q == ILPC_STOP;
	assign cnt_run   = cnt_q != '0;
	assign stab_last = (st_q == ILPC_STAB) & (cnt_q == CW'(1));

	// next state; a reset at any point lands in run via i_rst
	always_comb begin
		st_d = st_q;
		case (st_q)
			ILPC_RUN: begin
				if (sleep_req & ~pend_en) begin
					st_d = stop_ok ? ILPC_STOP : ILPC_WAIT;
				end
			end
			ILPC_WAIT: begin
				if (any_wake) st_d = ILPC_RUN;
			end
			ILPC_STOP: begin
				if (any_wake) st_d = ILPC_STAB;
			end
			ILPC_STAB: begin
				if (stab_last) st_d = ILPC_RUN;
			end
			default: st_d = ILPC_RUN;
		endcase
	end

	assign wake_go = ((st_q == ILPC_WAIT) & any_wake) | stab_last;

	// whether the wake also runs a service routine depends on sleep mode
	always_comb begin
		case (mode_q)
			ILPC_CORE_MAIN: svc_d = 1'b1;
			ILPC_CORE_NMI:  svc_d = 1'b0;
			ILPC_CORE_IRQ:  svc_d = nmi_pend;
			default:        svc_d = 1'b1;
		endcase
	end

	// sequencer registers; clock source selection never touched here
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st_q   <= ILPC_RUN;
			mode_q <= ILPC_CORE_MAIN;
			cnt_q  <= '0;
		end else begin
			st_q <= st_d;
			if (mode_cap) mode_q <= i_core_mode;
			if (cnt_load) cnt_q <= CW'(STAB_CYCLES);
			else if (cnt_run) cnt_q <= cnt_q - CW'(1);
		end
	end

	// ----------------------------------------------------------------
	// output next values
	// ----------------------------------------------------------------
	logic [4:0] irq_req_d;
	logic       sleep_skip_d;
	logic       core_halt_d;
	logic       osc_stop_d;
	logic       resume_service_d;
	logic [2:0] lp_state_d;

	// nmi presented to the core even with gen low; the sample strobe is not needed
	assign irq_req_d        = {req[4:1], nmi_pend} & {5{i_sample | 1'b1}};
	// a refused sleep is told to the core so it moves on
	assign sleep_skip_d     = (st_q == ILPC_RUN) & sleep_req & pend_en;
	// halt and oscillator follow the next state so they switch with it
	assign core_halt_d      = st_d != ILPC_RUN;
	assign osc_stop_d       = st_d == ILPC_STOP;
	// vector first only where the sleeping mode allows it
	assign resume_service_d = wake_go & svc_d;
	// one-hot state without its run bit
	assign lp_state_d       = st_d[3:1];

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// every output leaves a flip-flop, so the core sees no decode glitches
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_irq_req        <= '0;
			o_sleep_skip     <= 1'b0;
			o_core_halt      <= 1'b0;
			o_osc_stop       <= 1'b0;
			o_resume         <= 1'b0;
			o_resume_service <= 1'b0;
			o_opt_gen        <= 1'b0;
			o_lp_state       <= '0;
		end else begin
			o_irq_req        <= irq_req_d;
			o_sleep_skip     <= sleep_skip_d;
			o_core_halt      <= core_halt_d;
			o_osc_stop       <= osc_stop_d;
			o_resume         <= wake_go;
			o_resume_service <= resume_service_d;
			o_opt_gen        <= gen_q;
			o_lp_state       <= lp_state_d;
		end
	end
endmodule : ilpc_ctrl
`default_nettype wire

// File: ilpc_ctrl_checker.sv
// port assertions for the interrupt and low-power control block
`timescale 1ns/1ps
`default_nettype none
module ilpc_ctrl_checker #(
	parameter int STAB_CYCLES = 8
) (
	input wire logic       i_clock,
	input wire logic       i_rst,
	input wire logic       i_wr,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_bitop,
	input wire logic       i_wait_exec,
	input wire logic       i_stop_exec,
	input wire logic       i_watchdog_active,
	input wire logic [4:0] o_irq_req,
	input wire logic       o_sleep_skip,
	input wire logic       o_core_halt,
	input wire logic       o_osc_stop,
	input wire logic       o_resume,
	input wire logic       o_opt_gen,
	input wire logic [2:0] o_lp_state
);
	logic [15:0] stab_cnt_q;
	// settle counter, too long a count to unroll as a repetition
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) stab_cnt_q <= 16'h0000;
		else if (o_lp_state[2]) stab_cnt_q <= stab_cnt_q + 16'h0001;
		else stab_cnt_q <= 16'h0000;
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	AST_OPT_WR: assert property (i_wr && !i_bitop && i_addr == 8'hC8
		|-> ##2 o_opt_gen == $past(i_wdata[4], 2))
		else $error("gen bit not taken from write");
	AST_OPT_IGNORE: assert property (i_wr && (i_bitop || i_addr != 8'hC8) && !$past(i_wr)
		|-> ##2 o_opt_gen == $past(o_opt_gen, 2))
		else $error("gen changed by ignored write");
	AST_GEN_MASK: assert property (!o_opt_gen && !$past(o_opt_gen) |-> o_irq_req[4:1] == 4'h0)
		else $error("maskable request with gen low");
	AST_WAKE_GEN: assert property (o_resume |-> $past(o_opt_gen))
		else $error("wake while gen low");
	AST_HALT_CAUSE: assert property ($rose(o_core_halt) |-> $past(i_wait_exec || i_stop_exec))
		else $error("halt without sleep instruction");
	AST_OSC_WD: assert property ($rose(o_osc_stop) |-> $past(i_stop_exec && !i_watchdog_active))
		else $error("oscillator stopped without stop or with watchdog");
	AST_WAIT_OSC: assert property (o_lp_state[0] |-> o_core_halt && !o_osc_stop)
		else $error("wait state with oscillator off");
	AST_RESUME: assert property ($fell(o_core_halt) |-> o_resume)
		else $error("halt ended without resume");
	AST_SLEEP_ANSWER: assert property ((i_wait_exec || i_stop_exec) && o_lp_state == 3'h0 && !o_core_halt
		|=> o_core_halt != o_sleep_skip)
		else $error("sleep neither taken nor skipped");
	AST_STAB: assert property ($fell(o_lp_state[2]) |-> o_resume && stab_cnt_q >= STAB_CYCLES - 1)
		else $error("stop exit settle too short");
endmodule : ilpc_ctrl_checker
bind ilpc_ctrl ilpc_ctrl_checker #(.STAB_CYCLES(STAB_CYCLES)) u_ilpc_ctrl_checker (.i_clock, .i_rst, .i_wr,
	.i_addr, .i_wdata, .i_bitop, .i_wait_exec, .i_stop_exec, .i_watchdog_active, .o_irq_req, .o_sleep_skip,
	.o_core_halt, .o_osc_stop, .o_resume, .o_opt_gen, .o_lp_state);
`default_nettype wire

// File: ilpc_core_model.sv
// core model that acknowledges latched requests
`timescale 1ns/1ps
`default_nettype none
module ilpc_core_model (
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	input  wire logic       i_ack_en,
	input  wire logic [4:0] i_req,
	output logic            o_svc_start,
	output logic [2:0]      o_svc_src
);
	int gap_q;
	// lowest-numbered pending latched source first, random gap for slow cores
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_svc_start <= 1'h0;
			o_svc_src <= 3'h0;
			gap_q <= 0;
		end else begin
			o_svc_start <= 1'h0;
			if (i_ack_en && (|i_req[2:0]) && gap_q == 0) begin
				o_svc_start <= 1'h1;
				o_svc_src <= i_req[0] ? 3'h0 : (i_req[1] ? 3'h1 : 3'h2);
				gap_q <= $urandom_range(4, 1);
			end else if (gap_q > 0) gap_q <= gap_q - 1;
		end
	end
endmodule : ilpc_core_model
`default_nettype wire

// File: tb.sv
// self-checking bench of the interrupt and low-power control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ilpc_pkg::*;
	logic clk = 1'h0, rst = 1'h1, wr = 1'h0, bop = 1'h0, nmi_n = 1'h1, port = 1'h1, spi_n = 1'h1;
	logic wex = 1'h0, sex = 1'h0, wd = 1'h0, ack = 1'h0, svc, skip, halt, oscs, res, rsvc, gen;
	logic [7:0] addr = 8'h00, wdat = 8'h00, p = 8'h00;
	logic [2:0] src, lps, exq[$];
	logic [4:0] req;
	logic [31:0] r;
	ilpc_core_t mode = ILPC_CORE_MAIN;
	int miscompares = 0, n_tests = 0, cyc = 0, g;
	always #2.5 clk = ~clk;
	ilpc_ctrl #(.STAB_CYCLES(8)) u_ilpc_ctrl (.i_clock(clk), .i_rst(rst), .i_wr(wr), .i_addr(addr), .i_wdata(wdat),
		.i_bitop(bop), .i_nmi_pin_n(nmi_n), .i_port_irq_pin(port), .i_spi_done_pin_n(spi_n),
		.i_reload_overflow_flag(p[0]), .i_reload_overflow_irq_enable(p[1]), .i_compare_match_flag(p[2]),
		.i_compare_irq_enable(p[3]), .i_timer_zero_flag(p[4]), .i_timer_irq_enable(p[5]),
		.i_converter_eoc_flag(p[6]), .i_converter_irq_enable(p[7]), .i_sample(1'h0), .i_svc_start(svc),
		.i_svc_src(src), .i_core_mode(mode), .i_wait_exec(wex), .i_stop_exec(sex), .i_watchdog_active(wd),
		.o_irq_req(req), .o_sleep_skip(skip), .o_core_halt(halt), .o_osc_stop(oscs), .o_resume(res),
		.o_resume_service(rsvc), .o_opt_gen(gen), .o_lp_state(lps));
	ilpc_core_model u_ilpc_core_model (.i_clock(clk), .i_rst(rst), .i_ack_en(ack), .i_req(req),
		.o_svc_start(svc), .o_svc_src(src));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task automatic wro(input logic [7:0] a, input logic [7:0] d, input logic b);
		wr <= 1'h1;
		addr <= a;
		wdat <= d;
		bop <= b;
		tick(1);
		wr <= 1'h0;
		tick(2);
	endtask : wro
	task automatic pin(input int s, input logic v, input logic e);
		if (s == 1) spi_n <= v;
		else port <= v;
		tick(8);
		chk(req[s], e);
	endtask : pin
	task automatic ackt();
		ack <= 1'h1;
		tick(12);
		ack <= 1'h0;
		tick(1);
	endtask : ackt
	task automatic slp(input logic stp, input logic w, input ilpc_core_t m, input int k, input logic sv);
		int n;
		n = 0;
		mode <= m;
		wd <= w;
		sex <= stp;
		wex <= ~stp;
		tick(1);
		sex <= 1'h0;
		wex <= 1'h0;
		tick(2);
		chk({halt, oscs, lps}, {1'h1, stp & ~w, 1'h0, stp & ~w, ~(stp & ~w)});
		exq.push_back({1'h1, sv, 1'h0});
		if (k == 0) nmi_n <= 1'h0;
		else p <= 8'hC0;
		while (!res && n < 300) begin
			tick(1);
			n++;
		end
		chk(n > 9, stp & ~w);
		nmi_n <= 1'h1;
		p <= 8'h00;
		ackt();
	endtask : slp
	// each resume or refused sleep takes the oldest note
	always @(posedge clk) begin
		if (!rst && (res || skip)) begin
			if (exq.size() == 0) begin
				miscompares++;
				$display("wrong value at %0t: unexpected wake or skip", $time);
			end else chk({res, rsvc, skip}, exq.pop_front());
		end
	end
	// hang guard, well above the run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	initial begin
		r = $urandom(64);
		tick(20);
		rst <= 1'h0;
		tick(2);
		chk({halt, oscs, res, skip, gen, lps}, 8'h00);
		for (g = 0; g < 2; g++) begin
			wro(8'hC8, g[0] ? 8'h9F : 8'hEF, 1'h0);
			chk(gen, g[0]);
			repeat (16) begin
				r = $urandom;
				p <= r[7:0];
				tick(3);
				chk(req[4:3], {r[6] & r[7], (r[0] & r[1]) | (r[2] & r[3]) | (r[4] & r[5])} & {2{g[0]}});
			end
		end
		p <= 8'h00;
		wro(8'hC8, 8'h00, 1'h1);
		wro(8'hC9, 8'h00, 1'h0);
		chk(gen, 1'h1);
		pin(1, 1'h0, 1'h1);
		pin(1, 1'h1, 1'h1);
		ackt();
		chk(req[1], 1'h0);
		wro(8'hC8, 8'h50, 1'h0);
		pin(1, 1'h0, 1'h1);
		pin(1, 1'h1, 1'h0);
		pin(2, 1'h0, 1'h1);
		pin(2, 1'h1, 1'h1);
		ackt();
		wro(8'hC8, 8'h70, 1'h0);
		pin(2, 1'h0, 1'h0);
		pin(2, 1'h1, 1'h1);
		ackt();
		slp(1'h0, 1'h0, ILPC_CORE_MAIN, 4, 1'h1);
		slp(1'h1, 1'h0, ILPC_CORE_NMI, 0, 1'h0);
		slp(1'h1, 1'h1, ILPC_CORE_IRQ, 0, 1'h1);
		slp(1'h0, 1'h0, ILPC_CORE_IRQ, 4, 1'h0);
		p <= 8'hC0;
		tick(3);
		exq.push_back(3'h1);
		wex <= 1'h1;
		tick(1);
		wex <= 1'h0;
		tick(3);
		chk(halt, 1'h0);
		p <= 8'h00;
		wro(8'hC8, 8'h00, 1'h0);
		wex <= 1'h1;
		tick(1);
		wex <= 1'h0;
		nmi_n <= 1'h0;
		tick(30);
		chk({halt, req[0]}, 2'h3);
		rst <= 1'h1;
		tick(1);
		rst <= 1'h0;
		nmi_n <= 1'h1;
		tick(3);
		chk({halt, gen, oscs}, 3'h0);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
